// ### hdl/mtc_pkg.sv
// Constants, tables and coding functions of the symbol codec.
// Assumes a byte-wide register port and a byte-wide DMA stream.
package mtc_pkg;

  localparam logic [7:0] ADDR_LOW   = 8'hc2;
  localparam logic [7:0] ADDR_MID   = 8'hc3;
  localparam logic [7:0] ADDR_HIGH  = 8'hc4;
  localparam logic [7:0] ADDR_CTRL  = 8'hc5;

  localparam int BIT_READY  = 7;
  localparam int BIT_ERROR  = 6;
  localparam int BIT_ENC    = 5;
  localparam int BIT_DEC    = 4;
  localparam int BIT_DMA    = 2;
  localparam int BIT_ENDIAN = 1;
  localparam int BIT_MODE   = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES  = 8'hff;
  localparam int         BUF_DEPTH  = 2;

  // Six-bit symbol of each nibble, nibble 15 in the top slot.
  localparam logic [95:0] SYM_TABLE = {
    6'h29, 6'h32, 6'h31, 6'h34, 6'h23, 6'h26, 6'h25, 6'h2c,
    6'h13, 6'h1a, 6'h19, 6'h1c, 6'h0b, 6'h0e, 6'h0d, 6'h16};

  typedef enum logic [1:0] {IDLE, FETCH, CALC, PUSH} mtc_state_e;

  function automatic logic [5:0] sym_of(input logic [3:0] n);
    return SYM_TABLE[int'(n) * 6 +: 6];
  endfunction : sym_of

  // Returns the valid flag above the nibble.
  function automatic logic [4:0] nib_of_sym(input logic [5:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++)
      if (sym_of(4'(i)) == s)
        r = {1'b1, 4'(i)};
    return r;
  endfunction : nib_of_sym

  function automatic logic [7:0] man_of(input logic [3:0] n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++)
      r[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
    return r;
  endfunction : man_of

  function automatic logic [4:0] nib_of_man(input logic [7:0] b);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 4; i++)
    begin
      r[i] = (b[2*i +: 2] == 2'b01);
      if (b[2*i +: 2] == 2'b00 || b[2*i +: 2] == 2'b11)
        r[4] = 1'b0;
    end
    return r;
  endfunction : nib_of_man

  function automatic logic [1:0] bytes_in(input logic forward_start,
                                          input logic mode);
    return forward_start ? (mode ? 2'd2 : 2'd1) : (mode ? 2'd3 : 2'd2);
  endfunction : bytes_in

  function automatic logic [1:0] bytes_out(input logic forward_start,
                                           input logic mode);
    return forward_start ? (mode ? 2'd3 : 2'd2) : (mode ? 2'd2 : 2'd1);
  endfunction : bytes_out

endpackage : mtc_pkg

// ### hdl/mtc_buf.sv
// Small FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module mtc_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // The pointers wrap by overflow, so only powers of two are served.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_params
    $error("mtc_buf needs a power-of-two depth of at least two.");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mtc_buf

// ### hdl/mtc_codec.sv
// Manchester and three-out-of-six codec with byte register port.
// Assumes a byte register port and a DMA controller on two streams.
//
// How it works
// - Load three symbol bytes, then set decode
// - Ready set when a decode finishes
// - Any invalid six-bit symbol sets error
// - Symbol decode exactly inverts the encode table
// - Decode error can raise an interrupt
// - DMA decode continues; error stays sticky
// - Encode or decode start bit launches operation
// - Control layout: ready, error, starts, DMA
// - Mode bit: zero Manchester, one symbols
// - DMA uses big-endian ordering, bits set
// - Start bits self clear; ready stays set
// - Four nibbles become four six-bit symbols
// - Manchester encode: bit 0 gives 10
// - Invalid Manchester input gives error, all ones
`timescale 1ns/1ps
module mtc_codec (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       dma_in_valid,
  output logic            dma_in_ready,
  input  wire logic [7:0] dma_in_data,
  output logic            dma_out_valid,
  input  wire logic       dma_out_ready,
  output logic      [7:0] dma_out_data,
  output logic            err_irq
);
  mtc_pkg::mtc_state_e state_q;
  logic [23:0] data_q;
  logic        ready_q;
  logic        err_q;
  logic        enc_q;
  logic        dec_q;
  logic        dma_q;
  logic        endian_q;
  logic        mode_q;
  logic        op_enc_q;
  logic [1:0]  cnt_q;
  logic [23:0] res;
  logic        calc_err;
  logic        ctl_wr;
  logic        buf_valid;
  logic        buf_ready;
  logic [7:0]  buf_data;
  logic        in_take;

  assign ctl_wr  = sfr_wr && sfr_addr == mtc_pkg::ADDR_CTRL;
  assign in_take = dma_in_valid && dma_in_ready;
  assign err_irq = err_q;

  // Pure table lookups, one clock of work per operation.
  always_comb
  begin
    logic [4:0] a;
    logic [4:0] b;
    logic [4:0] c;
    logic [4:0] d;
    a = 5'h00;
    b = 5'h00;
    c = 5'h00;
    d = 5'h00;
    res = data_q;
    calc_err = 1'b0;
    if (op_enc_q)
    begin
      if (mode_q)
        res = {mtc_pkg::sym_of(data_q[15:12]),
               mtc_pkg::sym_of(data_q[11:8]),
               mtc_pkg::sym_of(data_q[7:4]),
               mtc_pkg::sym_of(data_q[3:0])};
      else
        res = {data_q[23:16], mtc_pkg::man_of(data_q[7:4]),
               mtc_pkg::man_of(data_q[3:0])};
    end
    else if (mode_q)
    begin
      a = mtc_pkg::nib_of_sym(data_q[23:18]);
      b = mtc_pkg::nib_of_sym(data_q[17:12]);
      c = mtc_pkg::nib_of_sym(data_q[11:6]);
      d = mtc_pkg::nib_of_sym(data_q[5:0]);
      calc_err = !(a[4] && b[4] && c[4] && d[4]);
      res = {data_q[23:16], a[3:0], b[3:0], c[3:0], d[3:0]};
    end
    else
    begin
      a = mtc_pkg::nib_of_man(data_q[15:8]);
      b = mtc_pkg::nib_of_man(data_q[7:0]);
      calc_err = !(a[4] && b[4]);
      res = {data_q[23:8],
             calc_err ? mtc_pkg::BYTE_ONES : {a[3:0], b[3:0]}};
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q  <= mtc_pkg::IDLE;
      cnt_q    <= 2'd0;
      op_enc_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        mtc_pkg::IDLE:
          if (enc_q || dec_q)
          begin
            op_enc_q <= enc_q;
            cnt_q    <= 2'd0;
            state_q  <= dma_q ? mtc_pkg::FETCH : mtc_pkg::CALC;
          end
        mtc_pkg::FETCH:
          if (!dma_q)
            state_q <= mtc_pkg::IDLE;
          else if (in_take)
          begin
            cnt_q <= cnt_q + 2'd1;
            if (cnt_q == mtc_pkg::bytes_in(op_enc_q, mode_q) - 2'd1)
              state_q <= mtc_pkg::CALC;
          end
        mtc_pkg::CALC:
        begin
          cnt_q   <= mtc_pkg::bytes_out(op_enc_q, mode_q) - 2'd1;
          state_q <= dma_q ? mtc_pkg::PUSH : mtc_pkg::IDLE;
        end
        mtc_pkg::PUSH:
          if (buf_ready)
          begin
            cnt_q <= cnt_q - 2'd1;
            if (cnt_q == 2'd0)
            begin
              cnt_q   <= 2'd0;
              state_q <= dma_q ? mtc_pkg::FETCH : mtc_pkg::IDLE;
            end
          end
      endcase
    end
  end

  // Software writes are ignored while the engine owns the data bytes.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      data_q <= {3{mtc_pkg::DATA_RESET}};
    else if (state_q == mtc_pkg::CALC)
      data_q <= res;
    else if (state_q == mtc_pkg::FETCH && in_take)
      data_q <= {data_q[15:0], dma_in_data};
    else if (state_q == mtc_pkg::IDLE && sfr_wr)
    begin
      if (sfr_addr == mtc_pkg::ADDR_LOW)
        data_q[7:0] <= sfr_wdata;
      if (sfr_addr == mtc_pkg::ADDR_MID)
        data_q[15:8] <= sfr_wdata;
      if (sfr_addr == mtc_pkg::ADDR_HIGH)
        data_q[23:16] <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      {ready_q, err_q, enc_q, dec_q} <= mtc_pkg::CTRL_RESET[7:4];
      {dma_q, endian_q, mode_q}      <= mtc_pkg::CTRL_RESET[2:0];
    end
    else
    begin
      if (ctl_wr)
      begin
        enc_q    <= sfr_wdata[mtc_pkg::BIT_ENC];
        dec_q    <= sfr_wdata[mtc_pkg::BIT_DEC];
        dma_q    <= sfr_wdata[mtc_pkg::BIT_DMA];
        endian_q <= sfr_wdata[mtc_pkg::BIT_ENDIAN];
        mode_q   <= sfr_wdata[mtc_pkg::BIT_MODE];
      end
      else if (state_q == mtc_pkg::IDLE)
      begin
        enc_q <= 1'b0;
        dec_q <= 1'b0;
      end
      // A flag set by the engine wins over a clearing write.
      if (state_q == mtc_pkg::CALC)
        ready_q <= 1'b1;
      else if (ctl_wr && !sfr_wdata[mtc_pkg::BIT_READY])
        ready_q <= 1'b0;
      if (state_q == mtc_pkg::CALC && calc_err)
        err_q <= 1'b1;
      else if (ctl_wr && !sfr_wdata[mtc_pkg::BIT_ERROR])
        err_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      unique case (sfr_addr)
        mtc_pkg::ADDR_LOW:  sfr_rdata <= data_q[7:0];
        mtc_pkg::ADDR_MID:  sfr_rdata <= data_q[15:8];
        mtc_pkg::ADDR_HIGH: sfr_rdata <= data_q[23:16];
        mtc_pkg::ADDR_CTRL:
          sfr_rdata <= {ready_q, err_q, enc_q, dec_q, 1'b0,
                        dma_q, endian_q, mode_q};
        default:            sfr_rdata <= 8'h00;
      endcase
  end

  // Output bytes leave most significant first, the big-endian order.
  assign dma_in_ready = (state_q == mtc_pkg::FETCH) && dma_q;
  assign buf_valid    = (state_q == mtc_pkg::PUSH);
  assign buf_data     = data_q[8*cnt_q +: 8];

  mtc_buf #(
    .WIDTH (8),
    .DEPTH (mtc_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (buf_data),
    .out_valid (dma_out_valid),
    .out_ready (dma_out_ready),
    .out_data  (dma_out_data)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  wire calc = (state_q == mtc_pkg::CALC);

  property p_ready_after_calc;
    calc |=> ready_q;
  endproperty
  a_ready_after_calc: assert property (p_ready_after_calc)
    else $error("Ready flag missing after an operation.");

  property p_start_self_clear;
    state_q == mtc_pkg::IDLE && (enc_q || dec_q) && !ctl_wr
      |=> !enc_q && !dec_q;
  endproperty
  a_start_self_clear: assert property (p_start_self_clear)
    else $error("Start bit did not clear itself.");

  property p_launch;
    state_q == mtc_pkg::IDLE && (enc_q || dec_q) && !dma_q
      |=> calc ##1 ready_q;
  endproperty
  a_launch: assert property (p_launch)
    else $error("Start bit did not launch an operation.");

  property p_err_sticky;
    err_q && !(ctl_wr && !sfr_wdata[mtc_pkg::BIT_ERROR]) |=> err_q;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("Error flag dropped without a clearing write.");

  property p_sym_err;
    calc && !op_enc_q && mode_q && calc_err |=> err_q && err_irq;
  endproperty
  a_sym_err: assert property (p_sym_err)
    else $error("Invalid symbol did not raise the error flag.");

  property p_man_ones;
    calc && !op_enc_q && !mode_q && calc_err
      |=> data_q[7:0] == mtc_pkg::BYTE_ONES && err_q;
  endproperty
  a_man_ones: assert property (p_man_ones)
    else $error("Bad Manchester input did not give all ones.");

  property p_enc_sym;
    calc && op_enc_q && mode_q
      |=> data_q[5:0] == mtc_pkg::sym_of($past(data_q[3:0]))
          && data_q[23:18] == mtc_pkg::sym_of($past(data_q[15:12]));
  endproperty
  a_enc_sym: assert property (p_enc_sym)
    else $error("Symbol encode result is wrong.");

  property p_dec_sym;
    calc && !op_enc_q && mode_q && !calc_err
      |=> mtc_pkg::sym_of(data_q[3:0]) == $past(data_q[5:0]);
  endproperty
  a_dec_sym: assert property (p_dec_sym)
    else $error("Symbol decode does not invert the encode.");

  property p_reserved_zero;
    sfr_rd && sfr_addr == mtc_pkg::ADDR_CTRL |=> !sfr_rdata[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bit read as one.");

  c_enc_sym: cover property (calc && op_enc_q && mode_q);
  c_dec_err: cover property (calc && !op_enc_q && calc_err);
  c_dma_push: cover property (buf_valid && !buf_ready);
  c_dma_loop: cover property (state_q == mtc_pkg::PUSH
                              ##1 state_q == mtc_pkg::FETCH);
endmodule : mtc_codec

// ### tb/mtc_dma_model.sv
// Behavioural model of the DMA controller on the codec's two byte streams.
// Assumes one rising-edge clock; the bench loads tx_q and reads rx_q.
`timescale 1ns/1ps
module mtc_dma_model (
  input  wire logic       core_clk,
  input  wire logic       slow,
  output logic            in_valid,
  input  wire logic       in_ready,
  output logic      [7:0] in_data,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_data
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  // Valid and ready settle at the first falling edge, well inside reset; in_data stays unknown until a byte is queued.
  logic [1:0] tick = 2'h0;

  // Bytes leave most significant first and are kept in arrival order.
  always @(posedge core_clk)
  begin
    if (in_valid && in_ready)
      void'(tx_q.pop_front());
    if (out_valid && out_ready)
      rx_q.push_back(out_data);
  end

  // A released data line shows the inverse so stale bytes cannot pass.
  always @(negedge core_clk)
  begin
    tick <= tick + 2'h1;
    in_valid <= (tx_q.size() > 0);
    in_data <= (tx_q.size() > 0) ? tx_q[0] : ~in_data;
    out_ready <= !slow || (tick == 2'h3);
  end
endmodule : mtc_dma_model

// ### tb/tb_top.sv
// Self-checking bench for the codec through its register port and DMA.
// Assumes the DMA model drives the streams and the bench the registers.
`timescale 1ns/1ps
module tb_top;
  logic       core_clk, reset, sfr_wr, sfr_rd, slow, err_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic       in_valid, in_ready, out_valid, out_ready;
  logic [7:0] in_data, out_data;
  int         num_errors, num_checks;

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  mtc_codec dut (.core_clk(core_clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .dma_in_valid(in_valid), .dma_in_ready(in_ready),
    .dma_in_data(in_data), .dma_out_valid(out_valid),
    .dma_out_ready(out_ready), .dma_out_data(out_data),
    .err_irq(err_irq));

  mtc_dma_model dma (.core_clk(core_clk), .slow(slow),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // The strobe drops for a full cycle so the next write never merges.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    @(negedge core_clk);
    d = sfr_rdata;
  endtask : rd

  task automatic op(input logic [7:0] c, input logic [7:0] h,
                    input logic [7:0] m, input logic [7:0] l);
    int n;
    wr(mtc_pkg::ADDR_CTRL, 8'h00);
    wr(mtc_pkg::ADDR_HIGH, h);
    wr(mtc_pkg::ADDR_MID, m);
    wr(mtc_pkg::ADDR_LOW, l);
    wr(mtc_pkg::ADDR_CTRL, c);
    rv = 8'h00;
    for (n = 0; n < 20 && rv[7] !== 1'b1; n++)
      rd(mtc_pkg::ADDR_CTRL, rv);
    if (rv[7] !== 1'b1)
    begin
      num_errors++;
      $display("BAD t=%0t ready flag never rose", $time);
    end
  endtask : op

  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 400 && dma.rx_q.size() < n; k++)
      @(negedge core_clk);
    if (dma.rx_q.size() < n)
    begin
      num_errors++;
      $display("BAD t=%0t too few output bytes", $time);
    end
  endtask : wait_rx

  task automatic wait_err;
    int k;
    for (k = 0; k < 100 && err_irq !== 1'b1; k++)
      @(negedge core_clk);
    if (err_irq !== 1'b1)
    begin
      num_errors++;
      $display("BAD t=%0t error flag never rose", $time);
    end
  endtask : wait_err

  initial
  begin
    #2000000;
    num_errors++;
    $display("BAD t=%0t watchdog ran out", $time);
    give_verdict();
  end

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    {sfr_wr, sfr_rd, slow} = 3'b000;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    rd(mtc_pkg::ADDR_CTRL, rv);
    chk(rv, mtc_pkg::CTRL_RESET);
    rd(mtc_pkg::ADDR_HIGH, rv);
    chk(rv, mtc_pkg::DATA_RESET);
    op(8'h20, 8'h00, 8'h00, 8'h5c);
    chk(rv, 8'h80);
    rd(mtc_pkg::ADDR_MID, rv);
    chk(rv, 8'h99);
    rd(mtc_pkg::ADDR_LOW, rv);
    chk(rv, 8'h5a);
    op(8'h10, 8'h00, 8'h99, 8'h5a);
    chk(rv, 8'h80);
    rd(mtc_pkg::ADDR_LOW, rv);
    chk(rv, 8'h5c);
    op(8'h10, 8'h00, 8'h99, 8'h5b);
    chk(rv, 8'hc0);
    chk({7'h00, err_irq}, 8'h01);
    rd(mtc_pkg::ADDR_LOW, rv);
    chk(rv, 8'hff);
    op(8'h21, 8'h00, 8'hc0, 8'h3f);
    chk(rv, 8'h81);
    rd(mtc_pkg::ADDR_HIGH, rv);
    chk(rv, 8'hd1);
    rd(mtc_pkg::ADDR_MID, rv);
    chk(rv, 8'h62);
    rd(mtc_pkg::ADDR_LOW, rv);
    chk(rv, 8'he9);
    op(8'h11, 8'hd1, 8'h62, 8'he9);
    chk(rv, 8'h81);
    rd(mtc_pkg::ADDR_MID, rv);
    chk(rv, 8'hc0);
    rd(mtc_pkg::ADDR_LOW, rv);
    chk(rv, 8'h3f);
    op(8'h11, 8'hd1, 8'h62, 8'hff);
    chk(rv, 8'hc1);
    wr(mtc_pkg::ADDR_CTRL, 8'h08);
    rd(mtc_pkg::ADDR_CTRL, rv);
    chk(rv, 8'h00);
    chk({7'h00, err_irq}, 8'h00);
    rd(8'hc6, rv);
    chk(rv, 8'h00);
    dma.tx_q = '{8'h5c, 8'h3a};
    wr(mtc_pkg::ADDR_CTRL, 8'h26);
    wait_rx(4);
    wr(mtc_pkg::ADDR_CTRL, 8'h00);
    chk(dma.rx_q[0], 8'h99);
    chk(dma.rx_q[1], 8'h5a);
    chk(dma.rx_q[2], 8'ha5);
    chk(dma.rx_q[3], 8'h66);
    // Receiver stalls here so the two-entry buffer fills up.
    slow = 1'b1;
    dma.rx_q.delete();
    dma.tx_q = '{8'hd1, 8'h62, 8'he9, 8'hd1, 8'h62, 8'hff,
                 8'hd1, 8'h62, 8'he9};
    wr(mtc_pkg::ADDR_CTRL, 8'h17);
    wait_rx(6);
    rd(mtc_pkg::ADDR_CTRL, rv);
    chk(rv & 8'h40, 8'h40);
    wr(mtc_pkg::ADDR_CTRL, 8'h00);
    chk(dma.rx_q[0], 8'hc0);
    chk(dma.rx_q[1], 8'h3f);
    chk(dma.rx_q[2], 8'hc0);
    chk(dma.rx_q[4], 8'hc0);
    chk(dma.rx_q[5], 8'h3f);
    // On the first error the input is stalled and the engine stopped.
    dma.rx_q.delete();
    dma.tx_q = '{8'hd1, 8'h62, 8'hff, 8'hd1, 8'h62, 8'he9};
    wr(mtc_pkg::ADDR_CTRL, 8'h17);
    wait_err();
    dma.tx_q.delete();
    wr(mtc_pkg::ADDR_CTRL, 8'h00);
    repeat (20) @(negedge core_clk);
    rd(mtc_pkg::ADDR_CTRL, rv);
    chk(rv, 8'h00);
    chk(8'(dma.rx_q.size()), 8'h02);
    chk(dma.rx_q[0], 8'hc0);
    give_verdict();
  end
endmodule : tb_top
